// File: src/lst_regs.svh
`ifndef LST_REGS_SVH
`define LST_REGS_SVH
// Time field limits
`define LST_SEC_LAST      6'h3b
`define LST_MIN_LAST      6'h3b
`define LST_HOUR_LAST     5'h17
`define LST_PRG_HOUR_LAST 7'h63
`define LST_LEAP_POS_SEC  6'h3c
`define LST_NEG_LAST_SEC  6'h3a
// Minute-of-day arithmetic for the zone offset and the deferred slot
`define LST_MIN_PER_HOUR  11'h03c
`define LST_MIN_PER_DAY   12'h5a0
`define LST_DAY_LAST_MIN  11'h59f
// Reset values
`define LST_TIME_RST      6'h00
`endif

// File: src/lst_pkg.sv
package lst_pkg;
  typedef logic [4:0] lst_hour_t;
  typedef logic [5:0] lst_ms_t;
  typedef logic [6:0] lst_prg_hour_t;
  // Leap handling state, Gray coded along idle -> armed -> done
  typedef enum logic [1:0] {
    LST_IDLE  = 2'b00,
    LST_ARMED = 2'b01,
    LST_DONE  = 2'b11
  } lst_leap_st_t;
endpackage

// File: src/lst_prog_timer.sv
`include "lst_regs.svh"
module lst_prog_timer #(
  parameter int HW = 7
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Controls
  input  wire logic          tick,
  input  wire logic          load,
  input  wire logic [HW-1:0] init_hh,
  input  wire logic [5:0]    init_mm,
  input  wire logic [5:0]    init_ss,
  input  wire logic          alarm_en,
  input  wire logic [HW-1:0] alarm_hh,
  input  wire logic [5:0]    alarm_mm,
  input  wire logic [5:0]    alarm_ss,
  // Counter and alarm
  output logic [HW-1:0]      hh_r,
  output logic [5:0]         mm_r,
  output logic [5:0]         ss_r,
  output logic               alarm_r
);
  logic [HW-1:0] hh_nxt;
  logic [5:0]    mm_nxt;
  logic [5:0]    ss_nxt;
  logic          ss_wrap;
  logic          mm_wrap;
  logic          hh_wrap;
  logic          match;

  // Carry chain for the seconds tick
  assign ss_wrap = (ss_r == `LST_SEC_LAST);
  assign mm_wrap = ss_wrap && (mm_r == `LST_MIN_LAST);
  assign hh_wrap = mm_wrap && (hh_r == HW'(`LST_PRG_HOUR_LAST));
  assign ss_nxt  = load ? init_ss : !tick ? ss_r : ss_wrap ? 6'h00 : ss_r + 6'h01;
  assign mm_nxt  = load ? init_mm : !(tick && ss_wrap) ? mm_r
                 : mm_wrap ? 6'h00 : mm_r + 6'h01;
  assign hh_nxt  = load ? init_hh : !(tick && mm_wrap) ? hh_r
                 : hh_wrap ? '0 : hh_r + HW'(1);
  // Compare against the next value so the alarm lines up with the count
  assign match   = alarm_en && !alarm_r && (hh_nxt == alarm_hh) && (mm_nxt == alarm_mm)
                 && (ss_nxt == alarm_ss) && (tick || load);

  // Counter registers; reset starts at zero until the first load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hh_r    <= '0;
      mm_r    <= `LST_TIME_RST;
      ss_r    <= `LST_TIME_RST;
      alarm_r <= 1'b0;
    end else begin
      hh_r    <= hh_nxt;
      mm_r    <= mm_nxt;
      ss_r    <= ss_nxt;
      alarm_r <= match;
    end
  end
endmodule // lst_prog_timer

// File: src/lst_leap_timer.sv
`include "lst_regs.svh"
// Notes on behaviour
// - Positive leap shows 23:59:60 before midnight
// - Negative leap jumps 23:59:58 to 00:00:00
// - Default adjustment at last UTC second
// - Midnight mode ignores local time zone
// - Deferred mode applies at local scheduled time
// - Program counter starts from initial value; after rst it counts from zero until a reset request
// - Any reset request reloads initial value
// - Initial value held as hours minutes seconds
// - Enabled alarm match pulses event and sets pin
// - Alarm value held as hours minutes seconds
module lst_leap_timer
  import lst_pkg::*;
#(
  parameter int PHW = 7
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Time source, from another domain
  input  wire logic              sec_tick,
  input  wire logic              leap_pending,
  input  wire logic              leap_negative,
  input  wire logic              set_time,
  input  wire lst_pkg::lst_hour_t set_hh,
  input  wire lst_pkg::lst_ms_t  set_mm,
  input  wire lst_pkg::lst_ms_t  set_ss,
  // Leap configuration
  input  wire logic              deferred_local_leap_mode,
  input  wire lst_pkg::lst_hour_t sched_hh,
  input  wire lst_pkg::lst_ms_t  sched_mm,
  input  wire logic              tz_negative,
  input  wire lst_pkg::lst_hour_t tz_hh,
  input  wire lst_pkg::lst_ms_t  tz_mm,
  // Program time requests and configuration
  input  wire logic              prg_reset_ui,
  input  wire logic              prg_reset_api,
  input  wire logic              prg_reset_gpi,
  input  wire logic [PHW-1:0]    prg_init_hh,
  input  wire lst_pkg::lst_ms_t  prg_init_mm,
  input  wire lst_pkg::lst_ms_t  prg_init_ss,
  input  wire logic              prg_alarm_en,
  input  wire logic [PHW-1:0]    prg_alarm_hh,
  input  wire lst_pkg::lst_ms_t  prg_alarm_mm,
  input  wire lst_pkg::lst_ms_t  prg_alarm_ss,
  // UTC time of day
  output lst_pkg::lst_hour_t     utc_hh,
  output lst_pkg::lst_ms_t       utc_mm,
  output lst_pkg::lst_ms_t       utc_ss,
  output logic                   leap_applied,
  output logic                   leap_armed,
  // Program time
  output logic [PHW-1:0]         prg_hh,
  output lst_pkg::lst_ms_t       prg_mm,
  output lst_pkg::lst_ms_t       prg_ss,
  output logic                   prg_alarm_event,
  output logic                   prg_alarm_gpo
);
  import lst_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  logic [NS-1:0] sync_d_r;
  logic [NS-1:0] raw_in;
  assign raw_in = {sec_tick, leap_pending, set_time, prg_reset_ui, prg_reset_api, prg_reset_gpi};

  // Two flops per pin, then a third stage for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r   <= '0;
      sync_r   <= '0;
      sync_d_r <= '0;
    end else begin
      meta_r   <= raw_in;
      sync_r   <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  logic [NS-1:0] rise;
  logic          tick;
  logic          pend_s;
  logic          set_s;
  logic          prg_load;
  assign rise     = sync_r & ~sync_d_r;
  assign tick     = rise[5];
  assign pend_s   = sync_r[4];
  assign set_s    = rise[3];
  assign prg_load = |rise[2:0];

  // ---------------------------------------------------------------
  // UTC time of day with leap handling
  // ---------------------------------------------------------------
  lst_hour_t    hh_r;
  lst_ms_t      mm_r;
  lst_ms_t      ss_r;
  lst_leap_st_t st_r;
  lst_leap_st_t st_nxt;
  logic         applied_r;
  logic         armed_r;
  logic         pend_d_r;

  // Local time = UTC + zone offset, in minutes of the day
  logic [10:0] utc_min;
  logic [10:0] tz_min;
  logic [11:0] loc_sum;
  logic [10:0] loc_min;
  logic [10:0] sched_min;
  assign utc_min   = 11'(hh_r) * `LST_MIN_PER_HOUR + 11'(mm_r);
  assign tz_min    = 11'(tz_hh) * `LST_MIN_PER_HOUR + 11'(tz_mm);
  assign loc_sum   = tz_negative ? 12'(utc_min) + `LST_MIN_PER_DAY - 12'(tz_min)
                                 : 12'(utc_min) + 12'(tz_min);
  assign loc_min   = (loc_sum >= `LST_MIN_PER_DAY) ? 11'(loc_sum - `LST_MIN_PER_DAY)
                                                   : 11'(loc_sum);
  assign sched_min = 11'(sched_hh) * `LST_MIN_PER_HOUR + 11'(sched_mm);

  // Leap takes place at the last second of the chosen minute
  logic at_utc_slot;
  logic at_loc_slot;
  logic at_slot;
  logic last_sec;
  logic pre_last;
  assign last_sec    = (ss_r == `LST_SEC_LAST);
  assign pre_last    = (ss_r == `LST_NEG_LAST_SEC);
  assign at_utc_slot = (hh_r == `LST_HOUR_LAST) && (mm_r == `LST_MIN_LAST);
  // Deferred slot ends at the scheduled local minute, so the second before it
  assign at_loc_slot = (loc_min == ((sched_min == 11'h000) ? `LST_DAY_LAST_MIN
                                                           : sched_min - 11'h001));
  assign at_slot     = deferred_local_leap_mode ? at_loc_slot : at_utc_slot;

  logic do_pos_hold;
  logic do_pos_end;
  logic do_neg;
  logic in_leap;
  assign in_leap     = (ss_r == `LST_LEAP_POS_SEC);
  assign do_pos_hold = tick && (st_r == LST_ARMED) && !leap_negative && at_slot && last_sec;
  assign do_pos_end  = tick && in_leap;
  assign do_neg      = tick && (st_r == LST_ARMED) && leap_negative && at_slot && pre_last;

  // Source drops pending after the event; a fresh rise re-arms
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      LST_IDLE:  if (pend_s && !pend_d_r) st_nxt = LST_ARMED;
      LST_ARMED: if (do_pos_hold || do_neg) st_nxt = LST_DONE;
      LST_DONE:  if (!pend_s) st_nxt = LST_IDLE;
      default:   st_nxt = LST_IDLE;
    endcase
  end

  // Normal carry plus the leap variants
  lst_hour_t hh_nxt;
  lst_ms_t   mm_nxt;
  lst_ms_t   ss_nxt;
  logic      roll;
  assign roll   = do_pos_end || do_neg || (tick && last_sec && !do_pos_hold);
  assign ss_nxt = set_s ? set_ss : do_pos_hold ? `LST_LEAP_POS_SEC
                : roll ? 6'h00 : tick ? ss_r + 6'h01 : ss_r;
  assign mm_nxt = set_s ? set_mm : !roll ? mm_r
                : (mm_r == `LST_MIN_LAST) ? 6'h00 : mm_r + 6'h01;
  assign hh_nxt = set_s ? set_hh : !(roll && mm_r == `LST_MIN_LAST) ? hh_r
                : (hh_r == `LST_HOUR_LAST) ? 5'h00 : hh_r + 5'h01;

  // Time registers and leap state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hh_r      <= 5'h00;
      mm_r      <= `LST_TIME_RST;
      ss_r      <= `LST_TIME_RST;
      st_r      <= LST_IDLE;
      applied_r <= 1'b0;
      armed_r   <= 1'b0;
      pend_d_r  <= 1'b0;
    end else begin
      hh_r      <= hh_nxt;
      mm_r      <= mm_nxt;
      ss_r      <= ss_nxt;
      st_r      <= st_nxt;
      applied_r <= do_pos_hold || do_neg;
      // Registered copy so the armed output comes straight from a flop
      armed_r   <= (st_nxt == LST_ARMED);
      pend_d_r  <= pend_s;
    end
  end

  assign utc_hh       = hh_r;
  assign utc_mm       = mm_r;
  assign utc_ss       = ss_r;
  assign leap_applied = applied_r;
  assign leap_armed   = armed_r;

  // ---------------------------------------------------------------
  // Program time counter
  // ---------------------------------------------------------------
  logic alarm_pulse;
  logic gpo_r;

  lst_prog_timer #(.HW(PHW)) u_prog (
    .clk      (clk),
    .rst      (rst),
    .tick     (tick),
    .load     (prg_load),
    .init_hh  (prg_init_hh),
    .init_mm  (prg_init_mm),
    .init_ss  (prg_init_ss),
    .alarm_en (prg_alarm_en),
    .alarm_hh (prg_alarm_hh),
    .alarm_mm (prg_alarm_mm),
    .alarm_ss (prg_alarm_ss),
    .hh_r     (prg_hh),
    .mm_r     (prg_mm),
    .ss_r     (prg_ss),
    .alarm_r  (alarm_pulse)
  );

  // Pin holds until the next reload or until the alarm is disabled, so slow GPI logic sees it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpo_r <= 1'b0;
    end else if (alarm_pulse) begin
      gpo_r <= 1'b1;
    end else if (prg_load || !prg_alarm_en) begin
      gpo_r <= 1'b0;
    end
  end

  assign prg_alarm_event = alarm_pulse;
  assign prg_alarm_gpo   = gpo_r;
endmodule // lst_leap_timer

// File: tb/lst_leap_timer_assertions.sv
module lst_chk
  import lst_pkg::*;
#(
  parameter int PHW = 7
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Watched
  input wire logic              leap_negative,
  input wire logic              leap_applied,
  input wire logic              leap_armed,
  input wire lst_pkg::lst_hour_t utc_hh,
  input wire lst_pkg::lst_ms_t  utc_mm,
  input wire lst_pkg::lst_ms_t  utc_ss,
  input wire logic [PHW-1:0]    prg_hh,
  input wire lst_pkg::lst_ms_t  prg_mm,
  input wire lst_pkg::lst_ms_t  prg_ss,
  input wire logic              prg_alarm_en,
  input wire logic [PHW-1:0]    prg_alarm_hh,
  input wire lst_pkg::lst_ms_t  prg_alarm_mm,
  input wire lst_pkg::lst_ms_t  prg_alarm_ss,
  input wire logic              prg_alarm_event,
  input wire logic              prg_alarm_gpo
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pos; leap_applied && !leap_negative; endsequence
  sequence s_neg; leap_applied && leap_negative; endsequence
  pos_leap_a: assert property (s_pos |-> utc_ss == 6'h3c)
    else $error("positive leap without second 60");
  neg_leap_a: assert property (s_neg |-> utc_ss == 6'h00 && $past(utc_ss) == 6'h3a)
    else $error("negative leap not from second 58");
  armed_clear_a: assert property (leap_applied |=> !leap_armed)
    else $error("leap still armed after apply");
  apply_once_a: assert property (leap_applied |=> !leap_applied [*8])
    else $error("leap applied twice");
  // Second 60 is in range here whether or not a leap is shown
  utc_range_a: assert property (utc_ss <= 6'h3c && utc_mm <= 6'h3b && utc_hh <= 5'h17)
    else $error("time of day out of range");
  prg_range_a: assert property (prg_ss <= 6'h3b && prg_mm <= 6'h3b)
    else $error("program field out of range");
  alarm_match_a: assert property (prg_alarm_event |-> prg_alarm_en &&
    {prg_hh, prg_mm, prg_ss} == {prg_alarm_hh, prg_alarm_mm, prg_alarm_ss})
    else $error("alarm without match");
  gpo_set_a: assert property (prg_alarm_event |-> ##[0:1] prg_alarm_gpo)
    else $error("alarm pin not raised");
  event_pulse_a: assert property (prg_alarm_event |=> !prg_alarm_event [*3])
    else $error("alarm event longer than a pulse");
  gpo_off_a: assert property (!prg_alarm_en [*4] |-> !prg_alarm_gpo)
    else $error("alarm pin high while disabled");
endmodule // lst_chk

bind lst_leap_timer lst_chk #(.PHW(PHW)) chk_u (.clk, .rst, .leap_negative, .leap_applied,
  .leap_armed, .utc_hh, .utc_mm, .utc_ss, .prg_hh, .prg_mm, .prg_ss, .prg_alarm_en,
  .prg_alarm_hh, .prg_alarm_mm, .prg_alarm_ss, .prg_alarm_event, .prg_alarm_gpo);

// File: tb/lst_time_src.sv
module lst_time_src
  import lst_pkg::*;
(
  // Clock and device feedback
  input  wire logic          clk,
  input  wire logic          leap_seen,
  // Time and leap data
  output logic               sec_tick,
  output logic               leap_pending,
  output logic               leap_negative,
  output logic               set_time,
  output lst_pkg::lst_hour_t set_hh,
  output lst_pkg::lst_ms_t   set_mm,
  output lst_pkg::lst_ms_t   set_ss
);
  timeunit 1ns;
  timeprecision 1ns;
  int utc_offset = 0;
  initial {sec_tick, leap_pending, leap_negative, set_time} = 4'h0;
  initial {set_hh, set_mm, set_ss} = 17'h0;
  // ----------
  // Source
  // ----------
  // Pending holds until the event, then the offset moves and pending drops
  always @(posedge clk) begin
    if (leap_seen === 1'b1) begin
      leap_pending <= 1'b0;
      utc_offset <= utc_offset + (leap_negative ? -1 : 1);
    end
  end
  // Pulses last two cycles so the device synchroniser cannot miss them
  task automatic tick();
    @(posedge clk) sec_tick <= 1'b1;
    repeat (2) @(posedge clk);
    sec_tick <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic set_t(input lst_hour_t h, input lst_ms_t m, input lst_ms_t s);
    @(posedge clk) {set_hh, set_mm, set_ss} <= {h, m, s};
    set_time <= 1'b1;
    repeat (2) @(posedge clk);
    set_time <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic announce(input logic neg);
    @(posedge clk) leap_negative <= neg;
    leap_pending <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // lst_time_src

// File: tb/test_leap_second_and_program_timer.sv
module test_leap_second_and_program_timer
  import lst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, deferred_local_leap_mode = 0, tz_negative = 0, prg_alarm_en = 0;
  logic prg_reset_ui = 0, prg_reset_api = 0, prg_reset_gpi = 0;
  lst_hour_t sched_hh = 0, tz_hh = 0;
  lst_ms_t sched_mm = 0, tz_mm = 0, prg_init_mm = 0, prg_init_ss = 0, prg_alarm_mm = 0;
  lst_ms_t prg_alarm_ss = 0;
  logic [6:0] prg_init_hh = 0, prg_alarm_hh = 0, prg_hh;
  logic sec_tick, leap_pending, leap_negative, set_time, leap_applied, leap_armed;
  logic prg_alarm_event, prg_alarm_gpo;
  lst_hour_t set_hh, utc_hh;
  lst_ms_t set_mm, set_ss, utc_mm, utc_ss, prg_mm, prg_ss;
  int n_errors = 0, samples_checked = 0, n_alarm = 0;
  lst_time_src src_u (.clk, .leap_seen(leap_applied), .sec_tick, .leap_pending, .leap_negative,
    .set_time, .set_hh, .set_mm, .set_ss);
  lst_leap_timer #(.PHW(7)) dut_u (.clk, .rst, .sec_tick, .leap_pending, .leap_negative,
    .set_time, .set_hh, .set_mm, .set_ss, .deferred_local_leap_mode, .sched_hh, .sched_mm,
    .tz_negative, .tz_hh, .tz_mm, .prg_reset_ui, .prg_reset_api, .prg_reset_gpi, .prg_init_hh,
    .prg_init_mm, .prg_init_ss, .prg_alarm_en, .prg_alarm_hh, .prg_alarm_mm, .prg_alarm_ss,
    .utc_hh, .utc_mm, .utc_ss, .leap_applied, .leap_armed, .prg_hh, .prg_mm, .prg_ss,
    .prg_alarm_event, .prg_alarm_gpo);
  // ----------
  // Helpers
  // ----------
  always #10 clk = ~clk;
  // The event lasts one cycle, so it is counted here rather than sampled late
  always @(posedge clk) if (prg_alarm_event === 1'b1) n_alarm++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [2:0] sel);
    @(posedge clk) {prg_reset_gpi, prg_reset_api, prg_reset_ui} <= sel;
    repeat (2) @(posedge clk);
    {prg_reset_gpi, prg_reset_api, prg_reset_ui} <= 3'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  // A west zone offset must not move the midnight insertion
  task automatic t_pos();
    {tz_negative, tz_hh} <= {1'b1, 5'h05};
    src_u.set_t(5'h17, 6'h3b, 6'h3b);
    src_u.announce(1'b0);
    chk(leap_armed, 1'b1);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, {5'h17, 6'h3b, 6'h3c});
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, 17'h0);
    chk(src_u.utc_offset, 32'h1);
  endtask
  task automatic t_neg();
    src_u.set_t(5'h17, 6'h3b, 6'h3a);
    src_u.announce(1'b1);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, 17'h0);
  endtask
  // Midnight passes untouched, the slot before 04:10 takes the leap once
  task automatic t_defer();
    {deferred_local_leap_mode, tz_negative, tz_hh, sched_hh, sched_mm} <= {2'h2, 5'h0, 5'h4, 6'ha};
    src_u.set_t(5'h17, 6'h3b, 6'h3b);
    src_u.announce(1'b0);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss, leap_armed}, {5'h0, 6'h0, 6'h0, 1'b1});
    src_u.set_t(5'h04, 6'h09, 6'h3b);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, {5'h04, 6'h09, 6'h3c});
    src_u.set_t(5'h04, 6'h09, 6'h3b);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, {5'h04, 6'h0a, 6'h00});
  endtask
  // Zone 4:30 west, deferred to 19:30 local, so the slot is UTC 23:59 again
  task automatic t_defer_neg();
    {tz_negative, tz_hh, tz_mm, sched_hh, sched_mm} <= {1'b1, 5'h04, 6'h1e, 5'h13, 6'h1e};
    src_u.set_t(5'h17, 6'h3b, 6'h3a);
    src_u.announce(1'b1);
    src_u.tick();
    chk({utc_hh, utc_mm, utc_ss}, 17'h0);
    chk(leap_armed, 1'b0);
    chk(src_u.utc_offset, 32'h0);
  endtask
  task automatic t_prog();
    prg_init_hh <= 7'h01;
    req(3'h1);
    chk({prg_hh, prg_mm, prg_ss}, {7'h01, 12'h0});
    src_u.tick();
    chk({prg_hh, prg_mm, prg_ss}, {7'h01, 12'h1});
    {prg_init_hh, prg_init_ss, prg_alarm_en, prg_alarm_mm} <= {7'h0, 6'h3b, 1'b1, 6'h01};
    req(3'h2);
    chk({prg_hh, prg_mm, prg_ss}, {7'h0, 6'h0, 6'h3b});
    src_u.tick();
    chk({prg_hh, prg_mm, prg_ss, n_alarm[3:0], prg_alarm_gpo}, {19'h40, 5'h3});
    req(3'h4);
    chk({prg_ss, prg_alarm_gpo}, {6'h3b, 1'b0});
    prg_alarm_en <= 1'b0;
    src_u.tick();
    chk(n_alarm, 1);
  endtask
  // ----------
  // Run
  // ----------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_pos();
    t_neg();
    t_defer();
    t_defer_neg();
    t_prog();
    test_done();
  end
  // Twenty-three transfers of seven to nine cycles each; this allows close to fifty times that
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule // test_leap_second_and_program_timer
